// *** rtl/rbp_packer.sv ***
// raw twelve-bit colour-mosaic packer, two pixels into three bytes
`default_nettype none
`include "rbp_defines.svh"
module rbp_packer
   import rbp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire rbp_pixel_t pixIn,
   input wire logic pixValid,
   output logic pixReady,
   output rbp_byte_beat_t byteOut,
   output logic byteValid,
   input wire logic byteReady,
   output rbp_colour_t pixColour,
   output logic [`RBP_PIX_CNT_W-1:0] pixIndex,
   output logic oddLine,
   output logic lineError
);
   rbp_state_t state;
   rbp_state_t next_state;
   rbp_sample_t firstPix;
   rbp_sample_t next_firstPix;
   rbp_sample_t secondPix;
   rbp_sample_t next_secondPix;
   logic [1:0] byteSel;
   logic [1:0] next_byteSel;
   logic pairLast;
   logic next_pairLast;
   logic pairFirst;
   logic next_pairFirst;
   logic parity;
   logic next_parity;
   logic next_pixReady;
   rbp_byte_beat_t next_byteOut;
   logic next_byteValid;
   rbp_colour_t next_pixColour;
   logic [`RBP_PIX_CNT_W-1:0] next_pixIndex;
   logic next_lineError;
   logic [3*`RBP_BYTE_W-1:0] pairBytes;
   logic take;
   logic outFree;

   // colour of a pixel from line parity and pixel parity
   function automatic rbp_colour_t colour_of(input logic oddLn, input logic oddPix);
      rbp_colour_t c;
      c = RBP_GREEN;
      if (!oddLn && !oddPix)
      begin
         c = RBP_BLUE;
      end
      else if (oddLn && oddPix)
      begin
         c = RBP_RED;
      end
      return c;
   endfunction : colour_of

   rbp_pair_pack u_pack (
      .firstPix(firstPix),
      .secondPix(secondPix),
      .pairBytes(pairBytes)
   );

   assign take = pixValid && pixReady;
   assign outFree = !byteValid || byteReady;

   // next state: collect two samples, then emit three bytes
   always_comb
   begin
      next_state = state;
      next_firstPix = firstPix;
      next_secondPix = secondPix;
      next_byteSel = byteSel;
      next_pairLast = pairLast;
      next_pairFirst = pairFirst;
      next_parity = parity;
      next_byteOut = byteOut;
      next_byteValid = byteValid && !byteReady;
      next_pixColour = pixColour;
      next_pixIndex = pixIndex;
      next_lineError = 1'b0;
      next_pixReady = pixReady;
      case (state)
         RBP_ST_FIRST:
         begin
            if (take)
            begin
               next_firstPix = pixIn.sample;
               next_pairFirst = pixIn.lineStart;
               if (pixIn.frameStart)
               begin
                  next_parity = 1'b0;
               end
               else if (pixIn.lineStart)
               begin
                  next_parity = !parity;
               end
               if (pixIn.lineStart)
               begin
                  next_pixIndex = '0;
               end
               else
               begin
                  next_pixIndex = pixIndex + 1'b1;
               end
               next_pixColour = colour_of(next_parity, 1'b0);
               next_lineError = pixIn.lineEnd; // line ended on an even pixel
               next_state = RBP_ST_SECOND;
            end
         end
         RBP_ST_SECOND:
         begin
            if (take)
            begin
               next_secondPix = pixIn.sample;
               next_pairLast = pixIn.lineEnd;
               next_pixIndex = pixIndex + 1'b1;
               next_pixColour = colour_of(parity, 1'b1);
               next_lineError = pixIn.lineStart;
               next_byteSel = 2'h0;
               next_pixReady = 1'b0;
               next_state = RBP_ST_TAIL;
            end
         end
         RBP_ST_TAIL:
         begin
            if (outFree)
            begin
               next_byteValid = 1'b1;
               next_byteOut.oddLine = parity;
               next_byteOut.lineStart = pairFirst && (byteSel == 2'h0);
               next_byteOut.lineEnd = pairLast && (byteSel == 2'h2);
               case (byteSel)
                  2'h0: next_byteOut.data = pairBytes[7:0];
                  2'h1: next_byteOut.data = pairBytes[15:8];
                  default: next_byteOut.data = pairBytes[23:16];
               endcase
               next_byteSel = byteSel + 2'h1;
               if (byteSel == 2'h2)
               begin
                  next_pixReady = 1'b1;
                  next_state = RBP_ST_FIRST;
               end
            end
         end
         default:
         begin
            next_state = RBP_ST_FIRST;
            next_pixReady = 1'b1;
         end
      endcase
   end

   // register every value
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= RBP_ST_FIRST;
         firstPix <= '0;
         secondPix <= '0;
         byteSel <= 2'h0;
         pairLast <= 1'b0;
         pairFirst <= 1'b0;
         parity <= 1'b0;
         pixReady <= 1'b1;
         byteOut <= '0;
         byteValid <= 1'b0;
         pixColour <= RBP_BLUE;
         pixIndex <= '0;
         lineError <= 1'b0;
      end
      else
      begin
         state <= next_state;
         firstPix <= next_firstPix;
         secondPix <= next_secondPix;
         byteSel <= next_byteSel;
         pairLast <= next_pairLast;
         pairFirst <= next_pairFirst;
         parity <= next_parity;
         pixReady <= next_pixReady;
         byteOut <= next_byteOut;
         byteValid <= next_byteValid;
         pixColour <= next_pixColour;
         pixIndex <= next_pixIndex;
         lineError <= next_lineError;
      end
   end

   assign oddLine = parity;

   // checks next to the packing path
   a_first_hi_byte: assert property (@(posedge clk_sys) disable iff (!rstn)
      (state == RBP_ST_TAIL && outFree && byteSel == 2'h0) |=>
      byteValid && byteOut.data == $past(firstPix[11:4]))
      else $error("first byte not high bits of first pixel");
   a_mid_nibbles: assert property (@(posedge clk_sys) disable iff (!rstn)
      (state == RBP_ST_TAIL && outFree && byteSel == 2'h1) |=>
      byteOut.data == {$past(secondPix[3:0]), $past(firstPix[3:0])})
      else $error("middle byte nibbles wrong");
   a_nibble_order: assert property (@(posedge clk_sys) disable iff (!rstn)
      (state == RBP_ST_TAIL && outFree && byteSel == 2'h1) |=>
      byteOut.data[7:4] == $past(secondPix[3:0]))
      else $error("second pixel nibble not in upper half");
   a_third_hi_byte: assert property (@(posedge clk_sys) disable iff (!rstn)
      (state == RBP_ST_TAIL && outFree && byteSel == 2'h2) |=>
      byteOut.data == $past(secondPix[11:4]))
      else $error("third byte not high bits of second pixel");
   a_three_bytes: assert property (@(posedge clk_sys) disable iff (!rstn)
      (state == RBP_ST_SECOND && take) |=> state == RBP_ST_TAIL && !pixReady)
      else $error("pair did not enter byte emission");
   a_line_end_odd: assert property (@(posedge clk_sys) disable iff (!rstn)
      (state == RBP_ST_TAIL && outFree && byteSel == 2'h2 && pairLast) |=>
      byteValid && byteOut.lineEnd && pixIndex[0])
      else $error("line end not on odd pixel");
   a_index_restart: assert property (@(posedge clk_sys) disable iff (!rstn)
      (state == RBP_ST_FIRST && take && pixIn.lineStart) |=> pixIndex == '0)
      else $error("pixel index not restarted");
   a_frame_even: assert property (@(posedge clk_sys) disable iff (!rstn)
      (state == RBP_ST_FIRST && take && pixIn.frameStart) |=> !oddLine && pixColour == RBP_BLUE)
      else $error("frame did not start on even line");
   a_odd_colours: assert property (@(posedge clk_sys) disable iff (!rstn)
      (state == RBP_ST_SECOND && take && oddLine) |=> pixColour == RBP_RED)
      else $error("odd pixel on odd line not red");
   a_sample_kept: assert property (@(posedge clk_sys) disable iff (!rstn)
      (state == RBP_ST_FIRST && take) |=> firstPix == $past(pixIn.sample))
      else $error("sample altered on capture");
   c_even_pair: cover property (@(posedge clk_sys) disable iff (!rstn)
      byteValid && byteOut.lineEnd && !byteOut.oddLine);
   c_odd_pair: cover property (@(posedge clk_sys) disable iff (!rstn)
      byteValid && byteOut.lineEnd && byteOut.oddLine);
   c_stall: cover property (@(posedge clk_sys) disable iff (!rstn)
      byteValid && !byteReady ##1 byteValid && byteReady);
   c_bad_line: cover property (@(posedge clk_sys) disable iff (!rstn) lineError);
endmodule : rbp_packer
`default_nettype wire

// *** rtl/rbp_defines.svh ***
// constants for the raw twelve-bit packer
`ifndef RBP_DEFINES_SVH
`define RBP_DEFINES_SVH
`define RBP_SAMPLE_W 12
`define RBP_BYTE_W 8
`define RBP_HI_MSB 11
`define RBP_HI_LSB 4
`define RBP_LO_MSB 3
`define RBP_LO_LSB 0
`define RBP_PIX_CNT_W 16
`define RBP_SAMPLE_MAX 12'hfff
`endif

// *** rtl/rbp_pkg.sv ***
// types shared by the raw twelve-bit packer
`default_nettype none
package rbp_pkg;
   `include "rbp_defines.svh"
   typedef logic [`RBP_SAMPLE_W-1:0] rbp_sample_t;
   typedef logic [`RBP_BYTE_W-1:0] rbp_byte_t;
   typedef enum logic [1:0] {RBP_BLUE = 2'h0, RBP_GREEN = 2'h1, RBP_RED = 2'h2} rbp_colour_t;
   // one pixel sample with its position markers
   typedef struct packed {
      rbp_sample_t sample;
      logic lineStart;
      logic frameStart;
      logic lineEnd;
   } rbp_pixel_t;
   // one output byte with its markers
   typedef struct packed {
      rbp_byte_t data;
      logic lineStart;
      logic lineEnd;
      logic oddLine;
   } rbp_byte_beat_t;
   typedef enum logic [2:0] {
      RBP_ST_FIRST = 3'h1,
      RBP_ST_SECOND = 3'h2,
      RBP_ST_TAIL = 3'h4
   } rbp_state_t;
endpackage : rbp_pkg
`default_nettype wire

// *** rtl/rbp_pair_pack.sv ***
// combinational packing of one pixel pair into three bytes
`default_nettype none
`include "rbp_defines.svh"
module rbp_pair_pack
   import rbp_pkg::*;
(
   input wire rbp_sample_t firstPix,
   input wire rbp_sample_t secondPix,
   output logic [3*`RBP_BYTE_W-1:0] pairBytes
);
   // byte0 high of first, byte1 low nibbles, byte2 high of second
   always_comb
   begin
      pairBytes[`RBP_BYTE_W-1:0] = firstPix[`RBP_HI_MSB:`RBP_HI_LSB];
      pairBytes[2*`RBP_BYTE_W-1:`RBP_BYTE_W] =
         {secondPix[`RBP_LO_MSB:`RBP_LO_LSB], firstPix[`RBP_LO_MSB:`RBP_LO_LSB]};
      pairBytes[3*`RBP_BYTE_W-1:2*`RBP_BYTE_W] = secondPix[`RBP_HI_MSB:`RBP_HI_LSB];
   end
endmodule : rbp_pair_pack
`default_nettype wire

// *** verification/rbp_host_sink.sv ***
// host image buffer model that takes bytes promptly or slowly
`default_nettype none
module rbp_host_sink
   import rbp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic slow,
   output logic byteReady
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] phase;
   // slow mode accepts one byte in every three cycles
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         phase <= 2'h0;
      else
         phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
   end
   assign byteReady = !slow || (phase == 2'h0);
endmodule : rbp_host_sink
`default_nettype wire

// *** verification/test_raw_bayer_12bit_packer.sv ***
// self-checking bench for the raw twelve-bit packer
`default_nettype none
`include "rbp_defines.svh"
module test_raw_bayer_12bit_packer;
   import rbp_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   rbp_pixel_t pixIn = '0;
   logic pixValid = 1'b0;
   logic slow = 1'b0;
   logic pixReady, byteValid, byteReady, oddLine, lineError;
   rbp_byte_beat_t byteOut;
   rbp_colour_t pixColour;
   logic [`RBP_PIX_CNT_W-1:0] pixIndex;
   rbp_byte_beat_t expQ[$];
   int numErrors = 0;
   int nTests = 0;
   int cycles = 0;
   int nBytes = 0;
   int nPix = 0;
   logic chkPix = 1'b0;
   logic curErr = 1'b0;
   logic errPix = 1'b0;
   logic [18:0] curPix = '0;
   logic [18:0] expPix = '0;

   rbp_packer rbp_packer_i (.clk_sys(clk_sys), .rstn(rstn), .pixIn(pixIn),
      .pixValid(pixValid), .pixReady(pixReady), .byteOut(byteOut), .byteValid(byteValid),
      .byteReady(byteReady), .pixColour(pixColour), .pixIndex(pixIndex), .oddLine(oddLine),
      .lineError(lineError));
   rbp_host_sink rbp_host_sink_i (.clk_sys(clk_sys), .rstn(rstn), .slow(slow),
      .byteReady(byteReady));

   // free-running clock
   always #50 clk_sys = ~clk_sys;

   task automatic giveVerdict();
      if (numErrors == 0 && nTests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : giveVerdict

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp)
      begin
         numErrors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // filter colour of a pixel from line parity and index
   function automatic rbp_colour_t colour_of(input logic odd, input int idx);
      if (odd)
         return (idx % 2) ? RBP_RED : RBP_GREEN;
      return (idx % 2) ? RBP_GREEN : RBP_BLUE;
   endfunction : colour_of

   // byte stream, pixel status and hang watch at each rising edge
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles > 20000)
      begin
         numErrors++;
         giveVerdict();
      end
      if (rstn)
         check(32'(lineError), chkPix ? 32'(errPix) : 32'h0);
      if (chkPix)
         check(32'({pixColour, pixIndex, oddLine}), 32'(expPix));
      chkPix <= pixValid && pixReady && rstn;
      expPix <= curPix;
      errPix <= curErr;
      if (byteValid && byteReady && rstn)
      begin
         nBytes++;
         if (expQ.size() == 0)
            check(32'(byteOut), 32'hffffffff);
         else
            check(32'(byteOut), 32'(expQ.pop_front()));
      end
   end

   // offer one pixel and hold it until taken
   task automatic send_pix(input rbp_sample_t s, input logic ls, input logic fs,
         input logic le, input logic odd, input int idx);
      pixIn <= '{s, ls, fs, le};
      pixValid <= 1'b1;
      curPix <= {colour_of(odd, idx), idx[15:0], odd};
      curErr <= (le && !idx[0]) || (ls && idx[0]); // marker on the wrong pixel of a pair
      nPix++;
      @(posedge clk_sys);
      while (pixReady !== 1'b1)
         @(posedge clk_sys);
   endtask : send_pix

   // one line of pairs; mode 1 and 2 give the extreme codes
   task automatic send_line(input int npix, input logic fs, input logic odd, input int mode,
         input logic bad);
      rbp_sample_t a;
      rbp_sample_t b;
      for (int i = 0; i < npix; i += 2)
      begin
         a = (mode == 1) ? 12'h000 : (mode == 2) ? 12'hfff : 12'($urandom);
         b = (mode == 1) ? 12'hfff : (mode == 2) ? 12'h000 : 12'($urandom);
         expQ.push_back('{a[11:4], i == 0, 1'b0, odd});
         expQ.push_back('{{b[3:0], a[3:0]}, 1'b0, 1'b0, odd});
         expQ.push_back('{b[11:4], 1'b0, i == npix - 2, odd});
         send_pix(a, i == 0, fs && i == 0, bad && i == npix - 2, odd, i);
         send_pix(b, bad && i == npix - 2, 1'b0, i == npix - 2, odd, i + 1);
      end
      pixValid <= 1'b0;
   endtask : send_line

   // frames of three lines, prompt and stalling sink in turn
   initial
   begin
      void'($urandom(22));
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      for (int f = 0; f < 6; f++)
      begin
         slow <= f[0];
         for (int l = 0; l < 3; l++)
         begin
            send_line((f == 0 && l == 0) ? 2 : 2 * $urandom_range(1, 8), l == 0, l[0],
               (f == 0) ? l : 0, 1'b0);
            repeat ($urandom_range(1, 4)) @(posedge clk_sys);
         end
      end
      // corner case: last pair with lineEnd on the even and lineStart on the odd pixel
      send_line(4, 1'b0, 1'b1, 0, 1'b1);
      while (expQ.size() != 0)
         @(posedge clk_sys);
      repeat (5) @(posedge clk_sys);
      check(32'(expQ.size()), 32'h0);
      check(32'(nBytes * 8), 32'(nPix * 12));
      giveVerdict();
   end
endmodule : test_raw_bayer_12bit_packer
`default_nettype wire
